//--- emb_bus_if.sv
// External program and data memory bus interface
// Function
// - Reset pin high two machine cycles resets
// - Store strobe every three states, skipped for data
// - Store strobe stays high for internal code
// - Latch strobe every three states, once per data cycle
// - Disable bit stops latch strobe, internal code
// - Program counter below 8000 fetches internally
// - Program counter above 7fff fetches externally
// - Upper port drives address high byte
// - Indirect register access shows upper latch, weak
// - Lower port multiplexes address then data
// - Idle lower port bit with one floats
// - Read strobe gates external data on bus
// - Sixteen bit program counter selects fetch source
// - Machine cycle is six one-clock states
// - Data move skips second cycle code fetches
`timescale 1ns/100ps
module emb_bus_if #(
	parameter int unsigned RESET_HOLD = emb_pkg::RESET_CYCLES
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        reset_pin,
	output logic             reset_active,
	// Configuration
	input  wire logic        external_access_pin,
	input  wire logic        latch_strobe_disable,
	input  wire logic        latch_strobe_disable_we,
	output logic             latch_strobe_disable_q,
	// Program counter and fetch
	input  wire logic        pc_load,
	input  wire logic [15:0] pc_load_value,
	input  wire logic        pc_keep,
	output logic [15:0]      program_counter,
	output logic             fetch_valid,
	output logic             fetch_external,
	output logic [7:0]       fetch_data,
	// On-chip code memory
	output logic [14:0]      rom_addr,
	input  wire logic [7:0]  rom_rdata,
	// External data move request
	input  wire logic        xdm_req,
	input  wire logic        xdm_write,
	input  wire logic        xdm_use_data_pointer,
	input  wire logic [15:0] xdm_addr,
	input  wire logic [7:0]  xdm_wdata,
	output logic             xdm_ack,
	output logic [7:0]       xdm_rdata,
	// Port latches
	input  wire logic [7:0]  upper_port_latch,
	input  wire logic [7:0]  lower_port_latch,
	// Bus pins
	output logic             address_latch_strobe,
	output logic             program_store_strobe_n,
	output logic             read_strobe_n,
	output logic             write_strobe_n,
	output logic [7:0]       lower_bus_out,
	output logic [7:0]       lower_bus_oe,
	input  wire logic [7:0]  lower_bus_in,
	output logic [7:0]       upper_port_out,
	output logic             upper_port_strong
);
	import emb_pkg::*;

	if (RESET_HOLD < 1) begin : g_chk
		$error("RESET_HOLD must be at least one");
	end

	logic core_reset;

	emb_reset_filter #(
		.HOLD_CYCLES (RESET_HOLD)
	) u_rst (
		.clk        (clk),
		.rst_n      (rst_n),
		.reset_pin  (reset_pin),
		.core_reset (core_reset)
	);

	// Idle lower port: open drain, a one floats, a zero pulls low
	logic [7:0] idle_oe;
	for (genvar i = 0; i < 8; i++) begin : g_idle
		assign idle_oe[i] = ~lower_port_latch[i];
	end

	// Sequencer and bus state
	emb_cycle_t  cyc_q, cyc_d;
	logic [2:0]  st_q, st_d;
	logic [15:0] pc_q, pc_d;
	logic [15:0] addr_q, addr_d;
	logic        ext_q, ext_d;
	logic        xw_q, xw_d;
	logic        xwide_q, xwide_d;
	logic [7:0]  xwd_q, xwd_d;
	logic        dis_q, dis_d;
	// Registered outputs
	logic        ale_q, ale_d;
	logic        program_store_strobe_n_q, program_store_strobe_n_d;
	logic        rd_n_q, rd_n_d;
	logic        wr_n_q, wr_n_d;
	logic [7:0]  lo_out_q, lo_out_d;
	logic [7:0]  lo_oe_q, lo_oe_d;
	logic [7:0]  hi_out_q, hi_out_d;
	logic        hi_str_q, hi_str_d;
	logic        fv_q, fv_d;
	logic        fext_q, fext_d;
	logic [7:0]  fdat_q, fdat_d;
	logic        ack_q, ack_d;
	logic [7:0]  rdat_q, rdat_d;
	logic [1:0]  pos;
	logic        fetch_end;

	always_comb begin
		cyc_d    = cyc_q;
		st_d     = (st_q == ST_LAST) ? ST_FIRST : st_q + 3'h1;
		pc_d     = pc_q;
		addr_d   = addr_q;
		ext_d    = ext_q;
		xw_d     = xw_q;
		xwide_d  = xwide_q;
		xwd_d    = xwd_q;
		dis_d    = latch_strobe_disable_we ? latch_strobe_disable : dis_q;
		fv_d     = 1'b0;
		fext_d   = fext_q;
		fdat_d   = fdat_q;
		ack_d    = 1'b0;
		rdat_d   = rdat_q;
		ale_d    = 1'b0;
		program_store_strobe_n_d = 1'b1;
		rd_n_d   = 1'b1;
		wr_n_d   = 1'b1;
		lo_out_d = '0;
		lo_oe_d  = idle_oe;
		hi_out_d = upper_port_latch;
		hi_str_d = 1'b0;
		pos      = POS_ALE;

		// Fetch completes at the last state of each half cycle
		fetch_end = (cyc_q == EMB_CYC_FETCH) && (st_q == 3'(POS_LAST) || st_q == ST_LAST);
		if (fetch_end) begin
			fv_d   = 1'b1;
			fext_d = ext_q;
			fdat_d = ext_q ? lower_bus_in : rom_rdata;
			if (pc_keep) begin
				pc_d = pc_q + PC_STEP;
			end
		end
		if (pc_load) begin
			pc_d = pc_load_value;
		end

		// Data cycle read data and completion
		if (cyc_q == EMB_CYC_DATA && st_q == ST_STROBE_LAST) begin
			ack_d = 1'b1;
			if (!xw_q) begin
				rdat_d = lower_bus_in;
			end
		end

		// A data move takes over the whole next machine cycle
		if (st_q == ST_LAST) begin
			if (cyc_q == EMB_CYC_FETCH && xdm_req) begin
				cyc_d   = EMB_CYC_DATA;
				addr_d  = xdm_addr;
				xw_d    = xdm_write;
				xwide_d = xdm_use_data_pointer;
				xwd_d   = xdm_wdata;
			end else begin
				cyc_d = EMB_CYC_FETCH;
			end
		end

		// Source of a fetch is chosen from the counter it will use
		if (cyc_d == EMB_CYC_FETCH && (st_d == ST_FIRST || st_d == ST_HALF2)) begin
			addr_d = pc_d;
			ext_d  = pc_d > INT_CODE_TOP;
		end

		if (cyc_d == EMB_CYC_FETCH) begin
			pos = (st_d >= ST_HALF2) ? 2'(st_d - ST_HALF2) : 2'(st_d);
			// Disable bit is honoured only for internal code
			ale_d = (pos == POS_ALE) && (ext_d || !dis_d);
			if (ext_d) begin
				program_store_strobe_n_d = (pos == POS_ALE);
				hi_out_d = addr_d[15:8];
				hi_str_d = 1'b1;
				if (pos == POS_ALE) begin
					lo_out_d = addr_d[7:0];
					lo_oe_d  = 8'hff;
				end else begin
					lo_oe_d = 8'h00;
				end
			end else begin
				program_store_strobe_n_d = 1'b1;
			end
		end else begin
			// One latch strobe for the data address, none for code
			ale_d = (st_d == ST_FIRST);
			if (xwide_d) begin
				hi_out_d = addr_d[15:8];
				hi_str_d = 1'b1;
			end else begin
				hi_out_d = upper_port_latch;
				hi_str_d = 1'b0;
			end
			if (st_d == ST_FIRST) begin
				lo_out_d = addr_d[7:0];
				lo_oe_d  = 8'hff;
			end else if (st_d <= ST_STROBE_LAST) begin
				rd_n_d   = xw_d;
				wr_n_d   = !xw_d;
				lo_out_d = xw_d ? xwd_d : 8'h00;
				lo_oe_d  = xw_d ? 8'hff : 8'h00;
			end else begin
				lo_oe_d = 8'h00;
			end
		end

		// Parked as a data tail so release never reports a fetch
		if (core_reset) begin
			cyc_d    = EMB_CYC_DATA;
			st_d     = ST_LAST;
			pc_d     = PC_RESET;
			addr_d   = PC_RESET;
			ext_d    = 1'b0;
			dis_d    = LATCH_DIS_RESET;
			fv_d     = 1'b0;
			ack_d    = 1'b0;
			ale_d    = 1'b0;
			program_store_strobe_n_d = 1'b1;
			rd_n_d   = 1'b1;
			wr_n_d   = 1'b1;
			lo_out_d = '0;
			lo_oe_d  = idle_oe;
			hi_out_d = upper_port_latch;
			hi_str_d = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cyc_q    <= EMB_CYC_DATA;
			st_q     <= ST_LAST;
			pc_q     <= PC_RESET;
			addr_q   <= PC_RESET;
			ext_q    <= 1'b0;
			xw_q     <= 1'b0;
			xwide_q  <= 1'b0;
			xwd_q    <= '0;
			dis_q    <= LATCH_DIS_RESET;
			fv_q     <= 1'b0;
			fext_q   <= 1'b0;
			fdat_q   <= '0;
			ack_q    <= 1'b0;
			rdat_q   <= '0;
			ale_q    <= 1'b0;
			program_store_strobe_n_q <= 1'b1;
			rd_n_q   <= 1'b1;
			wr_n_q   <= 1'b1;
			lo_out_q <= '0;
			lo_oe_q  <= '0;
			hi_out_q <= '0;
			hi_str_q <= 1'b0;
		end else begin
			cyc_q    <= cyc_d;
			st_q     <= st_d;
			pc_q     <= pc_d;
			addr_q   <= addr_d;
			ext_q    <= ext_d;
			xw_q     <= xw_d;
			xwide_q  <= xwide_d;
			xwd_q    <= xwd_d;
			dis_q    <= dis_d;
			fv_q     <= fv_d;
			fext_q   <= fext_d;
			fdat_q   <= fdat_d;
			ack_q    <= ack_d;
			rdat_q   <= rdat_d;
			ale_q    <= ale_d;
			program_store_strobe_n_q <= program_store_strobe_n_d;
			rd_n_q   <= rd_n_d;
			wr_n_q   <= wr_n_d;
			lo_out_q <= lo_out_d;
			lo_oe_q  <= lo_oe_d;
			hi_out_q <= hi_out_d;
			hi_str_q <= hi_str_d;
		end
	end

	// The access pin is assumed high; low would be undefined on this part
	logic ea_unused;
	assign ea_unused = external_access_pin;

	assign reset_active           = core_reset;
	assign latch_strobe_disable_q = dis_q;
	assign program_counter        = pc_q;
	assign fetch_valid            = fv_q;
	assign fetch_external         = fext_q;
	assign fetch_data             = fdat_q;
	assign rom_addr               = addr_q[14:0];
	assign xdm_ack                = ack_q;
	assign xdm_rdata              = rdat_q;
	assign address_latch_strobe   = ale_q;
	assign program_store_strobe_n = program_store_strobe_n_q;
	assign read_strobe_n          = rd_n_q;
	assign write_strobe_n         = wr_n_q;
	assign lower_bus_out          = lo_out_q;
	assign lower_bus_oe           = lo_oe_q;
	assign upper_port_out         = hi_out_q;
	assign upper_port_strong      = hi_str_q;
endmodule

//--- emb_bus_if_chk.sv
// Timing checker for the external memory bus pins
`timescale 1ns/100ps
module emb_bus_if_chk (
	// Clock and reset
	input wire logic       clk,
	input wire logic       rst_n,
	input wire logic       reset_active,
	// Data move handshake
	input wire logic       xdm_ack,
	// Bus pins
	input wire logic       address_latch_strobe,
	input wire logic       program_store_strobe_n,
	input wire logic       read_strobe_n,
	input wire logic       write_strobe_n,
	input wire logic [7:0] lower_bus_oe,
	input wire logic       upper_port_strong
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_program_store_strobe_after_ale: assert property ($fell(program_store_strobe_n) |-> $past(address_latch_strobe))
		else $error("store strobe without address latch");
	// A qualified reset may cut a fetch short
	a_program_store_strobe_two_low: assert property (disable iff (!rst_n || reset_active)
		$fell(program_store_strobe_n) |=> !program_store_strobe_n ##1 program_store_strobe_n)
		else $error("store strobe width wrong");
	a_ale_single: assert property (address_latch_strobe |=> !address_latch_strobe [*2])
		else $error("latch strobe too close");
	a_rd_width: assert property ($fell(read_strobe_n) |->
		$past(address_latch_strobe) ##0 !read_strobe_n [*4] ##1 read_strobe_n)
		else $error("read strobe shape wrong");
	a_rd_end_ack: assert property ($rose(read_strobe_n) |-> xdm_ack)
		else $error("read ended without ack");
	a_no_fetch_data: assert property (!read_strobe_n || !write_strobe_n |->
		program_store_strobe_n && !address_latch_strobe)
		else $error("fetch strobe during data access");
	a_rd_bus_free: assert property (!read_strobe_n |-> lower_bus_oe == 8'h00)
		else $error("low port driven during read");
	a_wr_bus_drive: assert property (!write_strobe_n |-> lower_bus_oe == 8'hff)
		else $error("low port not driven during write");
	a_fetch_hi_strong: assert property (!program_store_strobe_n |-> upper_port_strong)
		else $error("upper port weak during fetch");
	a_reset_idle: assert property (reset_active [*2] |->
		program_store_strobe_n && read_strobe_n && write_strobe_n)
		else $error("strobe active in reset");
endmodule
bind emb_bus_if emb_bus_if_chk emb_bus_if_chk_inst (.clk, .rst_n, .reset_active, .xdm_ack, .address_latch_strobe,
	.program_store_strobe_n, .read_strobe_n, .write_strobe_n, .lower_bus_oe, .upper_port_strong);

//--- emb_bus_if_tb.sv
// Self-checking bench for the external memory bus interface
`timescale 1ns/100ps
module emb_bus_if_tb;
	import emb_pkg::*;
	`define CHK(g, e, m) begin check_count++; if ((g) !== (e)) begin error_cnt++; $display("ERROR %0t %s", $time, m); end end
	typedef struct {logic [15:0] pc; logic dis; logic ext;} emb_row_t;
	emb_row_t    rows [5] = '{'{16'h0000, 1'b0, 1'b0}, '{16'h7fff, 1'b0, 1'b0}, '{16'h8000, 1'b0, 1'b1},
		'{16'hffff, 1'b1, 1'b1}, '{16'h1234, 1'b1, 1'b0}};
	logic        clk, rst_n, reset_pin, latch_strobe_disable, latch_strobe_disable_we, pc_load, pc_keep;
	logic        xdm_req, xdm_write, xdm_use_data_pointer, reset_active, latch_strobe_disable_q, fetch_valid;
	logic        fetch_external, xdm_ack, address_latch_strobe, program_store_strobe_n, read_strobe_n;
	logic        write_strobe_n, upper_port_strong;
	logic [15:0] pc_load_value, xdm_addr, program_counter, wr_addr;
	logic [7:0]  xdm_wdata, upper_port_latch, lower_port_latch, fetch_data, xdm_rdata, rom_rdata;
	logic [7:0]  lower_bus_out, lower_bus_oe, lower_bus_in, upper_port_out, wr_data;
	logic [14:0] rom_addr;
	int          error_cnt, check_count, cyc;
	integer      ale_cnt, program_store_strobe_cnt, a0, p0;
	assign rom_rdata = rom_addr[7:0] ^ 8'h3c;
	emb_bus_if #(.RESET_HOLD(12)) emb_bus_if_inst (.clk, .rst_n, .reset_pin, .reset_active,
		.external_access_pin(1'b1), .latch_strobe_disable, .latch_strobe_disable_we, .latch_strobe_disable_q,
		.pc_load, .pc_load_value, .pc_keep, .program_counter, .fetch_valid, .fetch_external, .fetch_data,
		.rom_addr, .rom_rdata, .xdm_req, .xdm_write, .xdm_use_data_pointer, .xdm_addr, .xdm_wdata, .xdm_ack,
		.xdm_rdata, .upper_port_latch, .lower_port_latch, .address_latch_strobe, .program_store_strobe_n,
		.read_strobe_n, .write_strobe_n, .lower_bus_out, .lower_bus_oe, .lower_bus_in, .upper_port_out,
		.upper_port_strong);
	emb_ext_mem emb_ext_mem_inst (.clk, .address_latch_strobe, .program_store_strobe_n, .read_strobe_n,
		.write_strobe_n, .lower_bus_out, .lower_bus_oe, .upper_port_out, .lower_bus_in, .wr_addr, .wr_data);
	always #2 clk = ~clk;
	always @(posedge clk) begin
		ale_cnt <= ale_cnt + address_latch_strobe;
		program_store_strobe_cnt <= program_store_strobe_cnt + !program_store_strobe_n;
		cyc <= cyc + 1;
		// Whole run needs under a thousand cycles
		if (cyc == 5000) begin
			error_cnt++;
			end_of_test();
		end
	end
	task automatic end_of_test();
		if (error_cnt == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic wait_fv(int n);
		repeat (n) begin
			@(negedge clk);
			while (fetch_valid !== 1'b1) @(negedge clk);
		end
	endtask
	task automatic xdm(logic w, logic dp, logic [15:0] a, logic [7:0] d);
		@(negedge clk);
		xdm_req = 1'b1;
		xdm_write = w;
		xdm_use_data_pointer = dp;
		xdm_addr = a;
		xdm_wdata = d;
		while (xdm_ack !== 1'b1) @(negedge clk);
		xdm_req = 1'b0;
		`CHK(upper_port_strong, dp, "upper port drive")
		`CHK(upper_port_out, dp ? a[15:8] : upper_port_latch, "upper port value")
	endtask
	initial begin
		{clk, rst_n, reset_pin, latch_strobe_disable, latch_strobe_disable_we, pc_load, pc_keep} = '0;
		{xdm_req, xdm_write, xdm_use_data_pointer, pc_load_value, xdm_addr, xdm_wdata} = '0;
		{error_cnt, check_count, cyc, ale_cnt, program_store_strobe_cnt} = '0;
		upper_port_latch = 8'h9e;
		lower_port_latch = 8'hf0;
		repeat (8) @(negedge clk);
		rst_n = 1'b1;
		foreach (rows[k]) begin
			@(negedge clk);
			pc_load = 1'b1;
			pc_load_value = rows[k].pc;
			latch_strobe_disable = rows[k].dis;
			latch_strobe_disable_we = 1'b1;
			@(negedge clk);
			pc_load = 1'b0;
			latch_strobe_disable_we = 1'b0;
			wait_fv(3);
			a0 = ale_cnt;
			p0 = program_store_strobe_cnt;
			`CHK(program_counter, rows[k].pc, "counter value")
			`CHK(fetch_external, rows[k].ext, "fetch source")
			`CHK(fetch_data, rows[k].pc[7:0] ^ (rows[k].ext ? rows[k].pc[15:8] ^ 8'h5a : 8'h3c), "fetch byte")
			`CHK(lower_bus_oe, rows[k].ext ? 8'hff : 8'h0f, "low port drive")
			wait_fv(2);
			`CHK(ale_cnt - a0, (rows[k].dis && !rows[k].ext) ? 0 : 2, "latch strobe count")
			`CHK(program_store_strobe_cnt - p0, rows[k].ext ? 4 : 0, "store strobe count")
		end
		// Counter steps over the top of on-chip code into external fetches
		@(negedge clk);
		pc_load = 1'b1;
		pc_load_value = 16'h7ffe;
		@(negedge clk);
		pc_load = 1'b0;
		wait_fv(1);
		pc_keep = 1'b1;
		wait_fv(2);
		pc_keep = 1'b0;
		`CHK(program_counter, 16'h8000, "counter step")
		`CHK({fetch_external, fetch_data}, {1'b0, 8'hff ^ 8'h3c}, "last on-chip fetch")
		wait_fv(1);
		`CHK({fetch_external, fetch_data}, {1'b1, 8'h00 ^ 8'h80 ^ 8'h5a}, "first external fetch")
		xdm(1'b0, 1'b1, 16'ha5c3, 8'h00);
		`CHK(xdm_rdata, 8'hc3 ^ 8'ha5 ^ 8'h5a, "pointer read data")
		xdm(1'b0, 1'b0, 16'h0042, 8'h00);
		`CHK(xdm_rdata, 8'h42 ^ 8'h9e ^ 8'h5a, "indirect read data")
		xdm(1'b1, 1'b1, 16'h8123, 8'h77);
		`CHK({wr_addr, wr_data}, 24'h812377, "write address and data")
		// Eleven cycles is one short of two machine cycles
		@(negedge clk);
		reset_pin = 1'b1;
		repeat (11) @(negedge clk);
		reset_pin = 1'b0;
		repeat (6) @(negedge clk);
		`CHK(reset_active, 1'b0, "short reset pulse taken")
		reset_pin = 1'b1;
		repeat (10) @(negedge clk);
		`CHK(reset_active, 1'b0, "reset taken early")
		repeat (4) @(negedge clk);
		`CHK(reset_active, 1'b1, "reset not taken")
		repeat (4) @(negedge clk);
		`CHK({program_counter, latch_strobe_disable_q, program_store_strobe_n}, {PC_RESET, 2'b01}, "reset state")
		reset_pin = 1'b0;
		repeat (4) @(negedge clk);
		`CHK(reset_active, 1'b0, "reset not released")
		wait_fv(3);
		`CHK(fetch_data, 8'h3c, "first fetch after reset")
		end_of_test();
	end
endmodule

//--- emb_ext_mem.sv
// External program and data memory with address latch
`timescale 1ns/100ps
module emb_ext_mem (
	// Bus pins, strobes only observed and never driven
	input wire logic        clk,
	input wire logic        address_latch_strobe,
	input wire logic        program_store_strobe_n,
	input wire logic        read_strobe_n,
	input wire logic        write_strobe_n,
	input wire logic [7:0]  lower_bus_out,
	input wire logic [7:0]  lower_bus_oe,
	input wire logic [7:0]  upper_port_out,
	output logic [7:0]      lower_bus_in,
	// Last write seen
	output logic [15:0]     wr_addr,
	output logic [7:0]      wr_data
);
	logic [15:0] addr_q;
	logic [7:0]  last_q;
	logic [7:0]  mem;
	assign mem = addr_q[7:0] ^ addr_q[15:8] ^ 8'h5a;
	// Open-drain port floats: released bits flip so stale data never passes
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (lower_bus_oe[i])
				lower_bus_in[i] = lower_bus_out[i];
			else if (!program_store_strobe_n || !read_strobe_n)
				lower_bus_in[i] = mem[i];
			else
				lower_bus_in[i] = ~last_q[i];
		end
	end
	always @(posedge clk) begin
		last_q <= lower_bus_in;
		if (address_latch_strobe)
			addr_q <= {upper_port_out, lower_bus_out};
		if (!write_strobe_n) begin
			wr_addr <= addr_q;
			wr_data <= lower_bus_out;
		end
	end
endmodule

//--- emb_pkg.sv
// Shared constants and types of the external memory bus interface
package emb_pkg;
	localparam int unsigned  STATES_PER_MC  = 6;
	localparam int unsigned  STATES_PER_HALF = 3;
	localparam int unsigned  RESET_MC       = 2;
	localparam int unsigned  RESET_CYCLES   = RESET_MC * STATES_PER_MC;
	localparam logic [2:0]   ST_FIRST       = 3'h0;
	localparam logic [2:0]   ST_HALF2       = 3'h3;
	localparam logic [2:0]   ST_STROBE_LAST = 3'h4;
	localparam logic [2:0]   ST_LAST        = 3'h5;
	localparam logic [1:0]   POS_ALE        = 2'h0;
	localparam logic [1:0]   POS_LAST       = 2'h2;
	localparam logic [15:0]  INT_CODE_TOP   = 16'h7fff;
	localparam logic [15:0]  PC_RESET       = 16'h0000;
	localparam logic [15:0]  PC_STEP        = 16'h0001;
	localparam logic         LATCH_DIS_RESET = 1'b0;

	typedef enum logic {
		EMB_CYC_FETCH,
		EMB_CYC_DATA
	} emb_cycle_t;
endpackage

//--- emb_reset_filter.sv
// Reset pin synchroniser and two machine cycle qualifier
`timescale 1ns/100ps
module emb_reset_filter #(
	parameter int unsigned HOLD_CYCLES = emb_pkg::RESET_CYCLES
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// Reset pin and qualified reset
	input  wire logic reset_pin,
	output logic      core_reset
);
	import emb_pkg::*;

	localparam int unsigned CW = $clog2(HOLD_CYCLES + 1);
	localparam logic [CW-1:0] HOLD_TOP  = CW'(HOLD_CYCLES);
	localparam logic [CW-1:0] HOLD_LAST = CW'(HOLD_CYCLES - 1);
	localparam logic [CW-1:0] CNT_ONE   = CW'(1);

	if (HOLD_CYCLES < 1) begin : g_chk
		$error("HOLD_CYCLES must be at least one");
	end

	logic          sync1_q;
	logic          sync2_q;
	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;
	logic          rst_q;
	logic          rst_d;

	// Held high after power-up only until the first clock, as the synchroniser resets low
	always_comb begin
		cnt_d = cnt_q;
		rst_d = rst_q;
		if (!sync2_q) begin
			cnt_d = '0;
			rst_d = 1'b0;
		end else begin
			// Count saturates so a long pulse keeps the reset held
			if (cnt_q != HOLD_TOP) begin
				cnt_d = cnt_q + CNT_ONE;
			end
			// The sample that completes the hold asserts reset at once
			if (cnt_q >= HOLD_LAST) begin
				rst_d = 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			cnt_q   <= '0;
			rst_q   <= 1'b1;
		end else begin
			sync1_q <= reset_pin;
			sync2_q <= sync1_q;
			cnt_q   <= cnt_d;
			rst_q   <= rst_d;
		end
	end

	assign core_reset = rst_q;
endmodule
